/* rtl/scp_port.v */
`timescale 1ns/100ps
`include "scp_defs.vh"
module scp_port (
   input  wire                   MCLK,
   input  wire                   SYS_RST,
   input  wire                   RESET_N,
   input  wire                   SLEEP_N,
   input  wire                   CS_N,
   input  wire                   SCLK,
   input  wire                   SDIO_I,
   output wire                   SDIO_O,
   output wire                   SDIO_OE,
   output wire                   SDO_O,
   output wire                   SDO_OE,
   output wire                   CORE_SLEEP,
   input  wire [`SCP_AW-1:0]     ACT_ADDR,
   output reg  [7:0]             ACT_DATA
);
   localparam ST_INSTR = 2'd0;
   localparam ST_DATA  = 2'd1;
   localparam ST_DONE  = 2'd2;
   localparam FW       = `SCP_AW + 8;

   // hard reset pin acts without the clock, like the system reset
   wire                rst_any;
   wire [3:0]          s_lvl;
   wire [3:0]          s_rise;
   wire [3:0]          s_fall;
   wire                cs_n_l;
   wire                din;
   wire                sclk_rise;
   wire                sclk_fall;
   wire                cs_rise;

   reg  [7:0]          shadow [0:`SCP_NREG-1];
   reg  [7:0]          active [0:`SCP_NREG-1];

   reg  [1:0]          state;
   reg  [2:0]          bit_cnt;
   reg                 instr_hi;
   reg  [15:0]         instr_sr;
   reg  [7:0]          data_sr;
   reg                 is_read;
   reg  [1:0]          len;
   reg  [1:0]          bytes_left;
   reg  [`SCP_AW-1:0]  addr;
   reg                 addr_bad;
   reg                 out_bit;
   reg                 wr_pend;
   reg  [FW-1:0]       wr_word;
   reg                 upd_pend;

   reg  [15:0]         next_instr;
   reg  [7:0]          next_data;
   reg  [`SCP_AW-1:0]  next_addr;
   reg  [2:0]          rd_idx;
   reg  [7:0]          rd_byte;

   wire                lsb_first;
   wire                sdo_active;
   wire                rd_active;
   wire                soft_rst;
   wire                drive;
   wire                fifo_in_ready;
   wire                fifo_out_valid;
   wire                fifo_out_ready;
   wire [FW-1:0]       fifo_out_data;
   wire [`SCP_AW-1:0]  drain_addr;
   wire [7:0]          drain_data;
   wire                drain;

   // decoded helpers shared by the state machine and the read and write paths
   wire                byte_done;
   wire                ins_rw;
   wire [1:0]          ins_len;
   wire [`SCP_AW-1:0]  ins_addr;
   wire                ins_addr_bad;
   wire                addr_at_top;
   wire                addr_at_zero;
   wire                rd_ok;
   integer             i;

   assign rst_any = SYS_RST | ~RESET_N;

   // a pin change is seen about four clocks late, so each serial level must
   // stand longer than that; slower hosts are fine, faster ones are not

   scp_sync #(
      .WIDTH (4),
      .INIT  (4'b1010)
   ) u_sync (
      .MCLK    (MCLK),
      .SYS_RST (SYS_RST),
      .PIN     ({SLEEP_N, SDIO_I, CS_N, SCLK}),
      .LVL     (s_lvl),
      .RISE    (s_rise),
      .FALL    (s_fall)
   );

   assign cs_n_l    = s_lvl[1];
   assign din       = s_lvl[2];
   assign sclk_rise = s_rise[0] & ~cs_n_l;
   assign sclk_fall = s_fall[0] & ~cs_n_l;
   assign cs_rise   = s_rise[1];

   // sleep only gates the clocking core; the port and registers carry on
   assign CORE_SLEEP = ~s_lvl[3];

   // serial-port settings act straight from the buffer, without update
   assign lsb_first  = shadow[`SCP_ADDR_CFG][`SCP_CFG_LSB_FIRST];
   assign sdo_active = shadow[`SCP_ADDR_CFG][`SCP_CFG_SDO_ACT];
   assign rd_active  = shadow[`SCP_ADDR_RDSRC][`SCP_RDSRC_BIT];
   assign soft_rst   = shadow[`SCP_ADDR_CFG][`SCP_CFG_SRST_LO] &
                       shadow[`SCP_ADDR_CFG][`SCP_CFG_SRST_HI];

   // address ends: the msb-first walk wraps from zero to the top, a stream stops at the top
   assign addr_at_top  = (addr == `SCP_ADDR_TOP);
   assign addr_at_zero = (addr == {`SCP_AW{1'b0}});
   // nonzero upper address bits or a hole above the map read back as zero
   assign rd_ok        = ~addr_bad & (addr <= `SCP_ADDR_TOP);

   // fields of the instruction as its sixteenth bit arrives
   assign ins_rw       = next_instr[`SCP_INS_RW];
   assign ins_len      = next_instr[`SCP_INS_LEN_HI:`SCP_INS_LEN_LO];
   assign ins_addr     = next_instr[`SCP_AW-1:0];
   assign ins_addr_bad = |next_instr[`SCP_INS_ADDR_HI:`SCP_AW];

   // a data byte is complete on its eighth rise, unless select rose in that cycle
   assign byte_done    = sclk_rise & ~cs_rise & (state == ST_DATA) & (bit_cnt == 3'd7);

   always @* begin
      next_instr = lsb_first ? {din, instr_sr[15:1]} : {instr_sr[14:0], din};
      next_data  = lsb_first ? {din, data_sr[7:1]} : {data_sr[6:0], din};
      if (lsb_first) begin
         next_addr = addr + 1'b1;
      end else if (addr_at_zero) begin
         next_addr = `SCP_ADDR_TOP;
      end else begin
         next_addr = addr - 1'b1;
      end
      rd_idx = lsb_first ? bit_cnt : 3'd7 - bit_cnt;
      if (!rd_ok) begin
         rd_byte = 8'h00;
      end else if (rd_active) begin
         rd_byte = active[addr];
      end else begin
         rd_byte = shadow[addr];
      end
   end

   // serial state machine; every step waits for a synchronised serial edge
   always @(posedge MCLK or posedge rst_any) begin
      if (rst_any) begin
         state      <= ST_INSTR;
         bit_cnt    <= 3'd0;
         instr_hi   <= 1'b0;
         instr_sr   <= 16'h0000;
         data_sr    <= 8'h00;
         is_read    <= 1'b0;
         len        <= 2'd0;
         bytes_left <= 2'd0;
         addr       <= {`SCP_AW{1'b0}};
         addr_bad   <= 1'b0;
      end else begin
         if (cs_rise) begin
            if (bit_cnt != 3'd0) begin
               // partial byte: flush and start over
               state    <= ST_INSTR;
               bit_cnt  <= 3'd0;
               instr_hi <= 1'b0;
            end else if (state == ST_DONE ||
                         (state == ST_DATA && len == `SCP_LEN_STREAM)) begin
               state    <= ST_INSTR;
               instr_hi <= 1'b0;
            end
            // otherwise a byte-boundary stall: keep all state and wait
         end else if (sclk_rise) begin
            case (state)
               ST_INSTR: begin
                  instr_sr <= next_instr;
                  bit_cnt  <= bit_cnt + 3'd1;
                  if (bit_cnt == 3'd7) begin
                     if (instr_hi) begin
                        is_read    <= ins_rw;
                        len        <= ins_len;
                        bytes_left <= ins_len;
                        addr       <= ins_addr;
                        addr_bad   <= ins_addr_bad;
                        instr_hi   <= 1'b0;
                        state      <= ST_DATA;
                     end else begin
                        instr_hi <= 1'b1;
                     end
                  end
               end
               ST_DATA: begin
                  data_sr <= next_data;
                  bit_cnt <= bit_cnt + 3'd1;
                  if (bit_cnt == 3'd7) begin
                     addr <= next_addr;
                     if (len == `SCP_LEN_STREAM) begin
                        if (addr_at_top) begin
                           state <= ST_DONE;
                        end
                     end else if (bytes_left == 2'd0) begin
                        state <= ST_DONE;
                     end else begin
                        bytes_left <= bytes_left - 2'd1;
                     end
                  end
               end
               ST_DONE: begin
                  bit_cnt <= bit_cnt + 3'd1;
               end
               default: begin
                  state <= ST_INSTR;
               end
            endcase
         end
      end
   end

   // the fresh byte wins over the handoff to the fifo when both fall in one cycle;
   // a full fifo is not expected at serial speed, so no back-pressure reaches the host
   always @(posedge MCLK or posedge rst_any) begin
      if (rst_any) begin
         wr_pend <= 1'b0;
         wr_word <= {FW{1'b0}};
      end else if (byte_done && !is_read) begin
         wr_pend <= ~addr_bad;
         wr_word <= {addr, next_data};
      end else if (fifo_in_ready) begin
         wr_pend <= 1'b0;
      end
   end

   // launching on the fall gives the host half a serial period before its rise
   always @(posedge MCLK or posedge rst_any) begin
      if (rst_any) begin
         out_bit <= 1'b0;
      end else if (sclk_fall && state == ST_DATA && is_read) begin
         out_bit <= rd_byte[rd_idx];
      end
   end

   // pins released unless select is low and read data is flowing
   assign drive   = ~cs_n_l & (state == ST_DATA) & is_read;
   assign SDIO_O  = out_bit;
   assign SDIO_OE = drive & ~sdo_active;
   assign SDO_O   = out_bit;
   assign SDO_OE  = drive & sdo_active;

   // the drain stalls for one cycle while an update copy runs
   assign fifo_out_ready = ~upd_pend;
   assign drain          = fifo_out_valid & fifo_out_ready;
   assign drain_addr     = fifo_out_data[FW-1:8];
   assign drain_data     = fifo_out_data[7:0];

   scp_fifo #(
      .WIDTH (FW),
      .DEPTH (`SCP_FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .MCLK      (MCLK),
      .SYS_RST   (rst_any),
      .IN_VALID  (wr_pend),
      .IN_READY  (fifo_in_ready),
      .IN_DATA   (wr_word),
      .OUT_VALID (fifo_out_valid),
      .OUT_READY (fifo_out_ready),
      .OUT_DATA  (fifo_out_data)
   );

   // an update written while soft reset holds is dropped, not deferred
   always @(posedge MCLK or posedge rst_any) begin
      if (rst_any) begin
         upd_pend <= 1'b0;
      end else if (drain && drain_addr == `SCP_ADDR_UPDATE &&
                   drain_data[`SCP_UPDATE_BIT] && !soft_rst) begin
         upd_pend <= 1'b1;
      end else begin
         upd_pend <= 1'b0;
      end
   end

   // buffer: serial writes land here
   always @(posedge MCLK or posedge rst_any) begin
      if (rst_any) begin
         shadow[0] <= `SCP_CFG_DEFAULT;
         for (i = 1; i < `SCP_NREG; i = i + 1) begin
            shadow[i] <= `SCP_REG_DEFAULT;
         end
      end else begin
         if (soft_rst) begin
            for (i = 1; i < `SCP_NREG; i = i + 1) begin
               shadow[i] <= `SCP_REG_DEFAULT;
            end
         end
         // while soft reset holds, only the config byte may be rewritten
         if (drain && drain_addr <= `SCP_ADDR_TOP &&
             (!soft_rst || drain_addr == `SCP_ADDR_CFG)) begin
            if (drain_addr == `SCP_ADDR_UPDATE) begin
               shadow[drain_addr] <= drain_data & 8'hFE;
            end else begin
               shadow[drain_addr] <= drain_data;
            end
         end
      end
   end

   // active registers change only by update, soft reset or reset
   always @(posedge MCLK or posedge rst_any) begin
      if (rst_any) begin
         active[0] <= `SCP_CFG_DEFAULT;
         for (i = 1; i < `SCP_NREG; i = i + 1) begin
            active[i] <= `SCP_REG_DEFAULT;
         end
      end else if (soft_rst) begin
         active[0] <= shadow[0];
         for (i = 1; i < `SCP_NREG; i = i + 1) begin
            active[i] <= `SCP_REG_DEFAULT;
         end
      end else if (upd_pend) begin
         for (i = 0; i < `SCP_NREG; i = i + 1) begin
            active[i] <= shadow[i];
         end
      end
   end

   // side read port for the core: one clock of latency, zero outside the map
   always @(posedge MCLK or posedge rst_any) begin
      if (rst_any) begin
         ACT_DATA <= 8'h00;
      end else if (ACT_ADDR <= `SCP_ADDR_TOP) begin
         ACT_DATA <= active[ACT_ADDR];
      end else begin
         ACT_DATA <= 8'h00;
      end
   end
endmodule // scp_port

/* rtl/scp_defs.vh */
// Contract
// - reset pin low restores all register defaults
// - soft reset while both mirrored bits set
// - soft reset needs no update command
// - port fully works while sleep pin low
// - registers keep contents across sleep
// - sample on rising, launch on falling
// - bidirectional after reset; bit0 selects unidirectional
// - both data pins released while select high
// - select may rise on byte boundaries, resumes; in stream mode the code ends the transfer instead
// - mid-byte select rise flushes, returns idle
// - streaming takes any byte count, address steps
// - sixteen-bit instruction comes first
// - length field picks 1-3 bytes or stream
// - stream visits every address, none skipped
// - writes buffered; update bit copies, self-clears
// - reads shift eight bits per byte
// - readback source chosen by bit readback_source_select[0]
// - register space spans serial_port_config to register_update_command
// - unidirectional readback only on separate pin
// - instruction: flag, length, 13-bit address
// - length codes 00/01/10 bytes, 11 stream
// - msb-first decrements, lsb-first increments address
// - stream stops after top register address
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

`define SCP_AW            10
`define SCP_NREG          563
`define SCP_ADDR_CFG      10'h000
`define SCP_ADDR_RDSRC    10'h004
`define SCP_ADDR_UPDATE   10'h232
`define SCP_ADDR_TOP      10'h232
`define SCP_CFG_DEFAULT   8'h18
`define SCP_REG_DEFAULT   8'h00

`define SCP_CFG_SDO_ACT   0
`define SCP_CFG_LSB_FIRST 1
`define SCP_CFG_SRST_LO   2
`define SCP_CFG_SRST_HI   5
`define SCP_RDSRC_BIT     0
`define SCP_UPDATE_BIT    0

`define SCP_INS_RW        15
`define SCP_INS_LEN_HI    14
`define SCP_INS_LEN_LO    13
`define SCP_INS_ADDR_HI   12
`define SCP_LEN_STREAM    2'h3

`define SCP_FIFO_DEPTH    8

`endif

/* rtl/scp_sync.v */
`timescale 1ns/100ps
// three-stage synchroniser; a change is taken once stages two and three agree
module scp_sync #(
   parameter WIDTH = 1,
   parameter INIT  = 0
) (
   input  wire             MCLK,
   input  wire             SYS_RST,
   input  wire [WIDTH-1:0] PIN,
   output reg  [WIDTH-1:0] LVL,
   output wire [WIDTH-1:0] RISE,
   output wire [WIDTH-1:0] FALL
);
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   reg [WIDTH-1:0] lvl_d;
   genvar g;

   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         always @(posedge MCLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               s1[g]    <= INIT[g];
               s2[g]    <= INIT[g];
               s3[g]    <= INIT[g];
               LVL[g]   <= INIT[g];
               lvl_d[g] <= INIT[g];
            end else begin
               s1[g]    <= PIN[g];
               s2[g]    <= s1[g];
               s3[g]    <= s2[g];
               if (s2[g] == s3[g]) begin
                  LVL[g] <= s3[g];
               end
               lvl_d[g] <= LVL[g];
            end
         end
      end
   endgenerate

   assign RISE = LVL & ~lvl_d;
   assign FALL = ~LVL & lvl_d;
endmodule // scp_sync

/* rtl/scp_fifo.v */
`timescale 1ns/100ps
module scp_fifo #(
   parameter WIDTH = 18,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             MCLK,
   input  wire             SYS_RST,
   input  wire             IN_VALID,
   output wire             IN_READY,
   input  wire [WIDTH-1:0] IN_DATA,
   output wire             OUT_VALID,
   input  wire             OUT_READY,
   output wire [WIDTH-1:0] OUT_DATA
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign IN_READY  = (count != DEPTH[AW:0]);
   assign OUT_VALID = (count != {(AW+1){1'b0}});
   assign OUT_DATA  = mem[rd_ptr];
   assign push      = IN_VALID & IN_READY;
   assign pop       = OUT_VALID & OUT_READY;

   always @(posedge MCLK) begin
      if (push) begin
         mem[wr_ptr] <= IN_DATA;
      end
   end

   always @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // scp_fifo

/* sim/scp_port_props.sv */
`timescale 1ns/100ps
`include "scp_defs.vh"
module scp_port_chk (
   input wire               MCLK,
   input wire               SYS_RST,
   input wire               RESET_N,
   input wire               SLEEP_N,
   input wire               CS_N,
   input wire               SCLK,
   input wire               SDIO_I,
   input wire               SDIO_O,
   input wire               SDIO_OE,
   input wire               SDO_O,
   input wire               SDO_OE,
   input wire               CORE_SLEEP,
   input wire [`SCP_AW-1:0] ACT_ADDR,
   input wire [7:0]         ACT_DATA
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   wire any_oe = SDIO_OE || SDO_OE;
   sequence pins_quiet;
      !SDIO_OE && !SDO_OE;
   endsequence
   sequence oe_held;
      any_oe [*8];
   endsequence
   pins_released_a: assert property (CS_N [*8] |-> pins_quiet)
      else $error("data pin driven while deselected");
   one_driver_a: assert property (!(SDIO_OE && SDO_OE))
      else $error("both data pins driven");
   launch_fall_a: assert property (any_oe && $past(any_oe) && $changed(SDO_O) |->
      !SCLK && !$past(SCLK, 3)) else $error("read bit changed away from a falling edge");
   oe_select_a: assert property (any_oe |-> !$past(CS_N, 6))
      else $error("pin driven without select");
   read_start_a: assert property ($rose(any_oe) |-> SCLK && $past(SCLK, 2))
      else $error("read drive began off a rising edge");
   read_byte_a: assert property ($rose(any_oe) |-> oe_held)
      else $error("read drive too short");
   sleep_flag_a: assert property ($stable(SLEEP_N) [*6] |-> CORE_SLEEP == !SLEEP_N)
      else $error("sleep flag wrong");
   hard_reset_a: assert property (!RESET_N |-> !any_oe && ACT_DATA == 8'h00)
      else $error("outputs active during hard reset");
   top_addr_a: assert property (ACT_ADDR > 10'h232 |=> ACT_DATA == 8'h00)
      else $error("data above register space");
endmodule // scp_port_chk
bind scp_port scp_port_chk scp_port_chk_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .RESET_N(RESET_N),
   .SLEEP_N(SLEEP_N), .CS_N(CS_N), .SCLK(SCLK), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O),
   .SDIO_OE(SDIO_OE), .SDO_O(SDO_O), .SDO_OE(SDO_OE), .CORE_SLEEP(CORE_SLEEP),
   .ACT_ADDR(ACT_ADDR), .ACT_DATA(ACT_DATA));

/* sim/scp_host.sv */
`timescale 1ns/100ps
module scp_host (
   output logic cs_n,
   output logic sclk,
   output logic sdio_i,
   input  wire  sdio_o,
   input  wire  sdio_oe,
   input  wire  sdo_o,
   input  wire  sdo_oe
);
   logic hd  = 1'b0;
   logic lsb = 1'b0;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
   end
   // the device owns the shared wire only while it drives it
   assign sdio_i = sdio_oe ? sdio_o : hd;
   task automatic start();
      cs_n = 1'b0;
      #32;
   endtask
   task automatic stop();
      #32 cs_n = 1'b1;
      #64;
   endtask
   task automatic shift(input logic [15:0] v, input int n, output logic [15:0] r);
      int k;
      r = 16'h0000;
      for (int i = 0; i < n; i++) begin
         k = lsb ? i : n - 1 - i;
         hd = v[k];
         #32 sclk = 1'b1;
         r[k] = sdo_oe ? sdo_o : (sdio_oe ? sdio_o : 1'bx);
         #32 sclk = 1'b0;
      end
      // inverted so a stale level never passes for fresh data
      hd = ~hd;
   endtask
endmodule // scp_host

/* sim/tb_top.sv */
`timescale 1ns/100ps
`include "scp_defs.vh"
module tb_top;
   logic               MCLK = 1'b0;
   logic               SYS_RST = 1'b1;
   logic               RESET_N = 1'b1;
   logic               SLEEP_N = 1'b1;
   logic [`SCP_AW-1:0] ACT_ADDR = 10'h000;
   wire                CS_N, SCLK, SDIO_I, SDIO_O, SDIO_OE, SDO_O, SDO_OE, CORE_SLEEP;
   wire  [7:0]         ACT_DATA;
   logic [7:0]         sh [0:`SCP_NREG-1];
   logic [7:0]         ac [0:`SCP_NREG-1];
   logic [7:0]         wb [0:7];
   logic [7:0]         rb [0:7];
   logic               lsb_m = 1'b0;
   int                 err_total = 0;
   int                 samples_checked = 0;
   int                 cyc = 0;
   always #2.5 MCLK = ~MCLK;
   scp_port scp_port_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .RESET_N(RESET_N), .SLEEP_N(SLEEP_N),
      .CS_N(CS_N), .SCLK(SCLK), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE),
      .SDO_O(SDO_O), .SDO_OE(SDO_OE), .CORE_SLEEP(CORE_SLEEP), .ACT_ADDR(ACT_ADDR),
      .ACT_DATA(ACT_DATA));
   scp_host scp_host_i (.cs_n(CS_N), .sclk(SCLK), .sdio_i(SDIO_I), .sdio_o(SDIO_O),
      .sdio_oe(SDIO_OE), .sdo_o(SDO_O), .sdo_oe(SDO_OE));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total = err_total + 1;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic mdl_reset();
      foreach (sh[i]) sh[i] = 8'h00;
      sh[0] = 8'h18;
      ac = sh;
   endtask
   function automatic logic [9:0] nxt(input logic [9:0] a);
      return lsb_m ? a + 10'h001 : (a == 10'h000 ? 10'h232 : a - 10'h001);
   endfunction
   task automatic op(input logic rw, input logic [1:0] len, input logic [9:0] a,
                     input int n, input logic st);
      logic [15:0] r;
      scp_host_i.start();
      scp_host_i.shift({rw, len, 3'b000, a}, 16, r);
      for (int i = 0; i < n; i++) begin
         if (st) begin
            scp_host_i.stop();
            scp_host_i.start();
         end
         scp_host_i.shift({8'h00, wb[i]}, 8, r);
         rb[i] = r[7:0];
      end
      scp_host_i.stop();
   endtask
   task automatic wexp(input logic [9:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         if (a == 10'h232 && wb[i][0]) ac = sh;
         else sh[a] = wb[i];
         if (a == 10'h232) break;
         a = nxt(a);
      end
   endtask
   task automatic wr1(input logic [9:0] a, input logic [7:0] d);
      wb[0] = d;
      op(1'b0, 2'b00, a, 1, 1'b0);
      wexp(a, 1);
   endtask
   task automatic rchk(input logic [9:0] a, input int n);
      op(1'b1, n > 3 ? 2'b11 : 2'(n - 1), a, n, 1'b0);
      for (int i = 0; i < n; i++) begin
         chk("readback", rb[i], sh[4][0] ? ac[a] : sh[a]);
         a = nxt(a);
      end
   endtask
   task automatic achk(input logic [9:0] a);
      @(posedge MCLK) ACT_ADDR <= a;
      repeat (3) @(posedge MCLK);
      #1 chk("active", ACT_DATA, a > 10'h232 ? 8'h00 : ac[a]);
   endtask
   initial begin
      logic [9:0]  a;
      logic [9:0]  b;
      logic [15:0] r;
      int          n;
      mdl_reset();
      void'($urandom(32'h4a79));
      repeat (6) @(posedge MCLK);
      SYS_RST <= 1'b0;
      repeat (4) @(posedge MCLK);
      rchk(10'h000, 1);
      rchk(10'h004, 1);
      rchk(10'h232, 1);
      $display("test defaults done");
      for (int j = 0; j < 6; j++) begin
         a = 10'h010 + 10'($urandom % 500);
         n = 1 + j % 3;
         foreach (wb[i]) wb[i] = 8'($urandom);
         op(1'b0, 2'(n - 1), a, n, j[0]);
         wexp(a, n);
         rchk(a, n);
         achk(a);
      end
      $display("test buffered writes done");
      wr1(10'h232, 8'h01);
      achk(a);
      rchk(10'h232, 1);
      wr1(10'h004, 8'h01);
      rchk(a, 3);
      wr1(10'h004, 8'h00);
      $display("test update done");
      b = 10'h100;
      scp_host_i.start();
      scp_host_i.shift({6'h00, b}, 16, r);
      scp_host_i.shift(16'h00a5, 4, r);
      scp_host_i.stop();
      rchk(b, 1);
      scp_host_i.start();
      scp_host_i.shift({6'h08, b}, 16, r);
      scp_host_i.shift(16'h0066, 8, r);
      scp_host_i.stop();
      scp_host_i.start();
      scp_host_i.shift(16'h0005, 3, r);
      scp_host_i.stop();
      sh[b] = 8'h66;
      scp_host_i.start();
      scp_host_i.shift({6'h01, b}, 16, r);
      scp_host_i.shift(16'h00ee, 8, r);
      scp_host_i.stop();
      rchk(b, 2);
      $display("test abort done");
      wr1(10'h000, 8'h5a);
      lsb_m = 1'b1;
      scp_host_i.lsb = 1'b1;
      foreach (wb[i]) wb[i] = 8'($urandom);
      wb[4] = 8'h00;
      op(1'b0, 2'b11, 10'h22e, 6, 1'b0);
      wexp(10'h22e, 6);
      rchk(10'h22e, 5);
      rchk(10'h000, 1);
      wr1(10'h000, 8'h18);
      lsb_m = 1'b0;
      scp_host_i.lsb = 1'b0;
      $display("test stream done");
      wr1(10'h000, 8'h99);
      rchk(a, 3);
      wr1(10'h000, 8'h18);
      $display("test separate pin done");
      @(posedge MCLK) SLEEP_N <= 1'b0;
      b = 10'h1f0;
      wr1(b, 8'h3c);
      rchk(b, 1);
      chk("sleep", {7'h00, CORE_SLEEP}, 8'h01);
      @(posedge MCLK) SLEEP_N <= 1'b1;
      achk(a);
      $display("test sleep done");
      wr1(10'h000, 8'h3c);
      mdl_reset();
      sh[0] = 8'h3c;
      rchk(b, 1);
      achk(a);
      wr1(10'h000, 8'h18);
      $display("test soft reset done");
      wr1(b, 8'h77);
      wr1(10'h232, 8'h01);
      achk(b);
      @(posedge MCLK) RESET_N <= 1'b0;
      @(posedge MCLK) RESET_N <= 1'b1;
      mdl_reset();
      achk(b);
      rchk(b, 1);
      rchk(10'h000, 1);
      achk(10'h3ff);
      $display("test hard reset done");
      complete_run();
   end
endmodule // tb_top
